// ===== ffl_pkg.sv
// Package: register map, field positions and reset values for the FIFO bookkeeping block
`default_nettype none
package ffl_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [4:0] FFL_ADDR_FILL_STATUS = 5'h1c;
    localparam logic [4:0] FFL_ADDR_TX_UPPER = 5'h1d;
    localparam logic [4:0] FFL_ADDR_TX_LOWER = 5'h1e;
    // --------------------------------------------------------------
    // Field positions and values
    // --------------------------------------------------------------
    localparam int FFL_OVF_BIT = 7;
    localparam int FFL_PARTIAL_FLAG_BIT = 0;
    localparam logic [7:0] FFL_TX_RESET = 8'h00;
    localparam logic [7:0] FFL_FIFO_DEPTH = 8'h7f;
    localparam logic [7:0] FFL_UNMAPPED_READ = 8'h00;
    localparam logic [3:0] FFL_FULL_BYTE_BITS = 4'h8;
endpackage
`default_nettype wire

// ===== ffl_regs.sv
// FIFO fill status and transmit length registers
`default_nettype none
module ffl_regs
    import ffl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic chip_en,
    input wire logic [4:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic fifo_push,
    input wire logic fifo_pop,
    input wire logic fifo_clear,
    input wire logic tx_eof,
    output logic [11:0] complete_byte_count,
    output logic [2:0] partial_bit_count,
    output logic partial_flag,
    output logic [3:0] last_byte_bits,
    output logic [6:0] fill_level_bits,
    output logic fifo_overflow
);
    // --------------------------------------------------------------
    // Fill level and overflow tracking
    // --------------------------------------------------------------
    logic [6:0] level_r, level_nxt;
    logic ovf_r, ovf_nxt;
    logic [7:0] upper_r, upper_nxt;
    logic [7:0] lower_r, lower_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Write strobe aimed at one register offset
    function automatic logic wr_hit(input logic wr, input logic [4:0] addr, input logic [4:0] want);
        return wr && (addr == want);
    endfunction

    // Push into a full FIFO is lost and flagged; pop on empty does nothing
    always_comb begin
        level_nxt = level_r;
        ovf_nxt = ovf_r;
        if (fifo_clear) begin
            level_nxt = 7'h00;
            ovf_nxt = 1'b0;
            // Set beats clear: a byte lost in the clear cycle must still be reported
            if (fifo_push && !fifo_pop && {1'b0, level_r} == FFL_FIFO_DEPTH) begin
                ovf_nxt = 1'b1;
            end
        end else begin
            if (fifo_push && !(fifo_pop && level_r != 7'h00)) begin
                if ({1'b0, level_r} == FFL_FIFO_DEPTH) begin
                    ovf_nxt = 1'b1;
                end else begin
                    level_nxt = level_r + 7'h01;
                end
            end else if (fifo_pop && !fifo_push && level_r != 7'h00) begin
                level_nxt = level_r - 7'h01;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !chip_en) begin
            level_r <= 7'h00;
            ovf_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // --------------------------------------------------------------
    // Transmit length registers
    // --------------------------------------------------------------
    // Frame end beats a host write in the same cycle, so a stale length never survives
    always_comb begin
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        if (tx_eof) begin
            upper_nxt = FFL_TX_RESET;
            lower_nxt = FFL_TX_RESET;
        end else if (wr_hit(reg_wr, reg_addr, FFL_ADDR_TX_UPPER)) begin
            upper_nxt = reg_wdata;
        end else if (wr_hit(reg_wr, reg_addr, FFL_ADDR_TX_LOWER)) begin
            lower_nxt = reg_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst || !chip_en) begin
            upper_r <= FFL_TX_RESET;
            lower_r <= FFL_TX_RESET;
        end else begin
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
        end
    end

    // --------------------------------------------------------------
    // Read port
    // --------------------------------------------------------------
    // Status register has no write path at all
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                FFL_ADDR_FILL_STATUS: rdata_nxt = {ovf_r, level_r};
                FFL_ADDR_TX_UPPER: rdata_nxt = upper_r;
                FFL_ADDR_TX_LOWER: rdata_nxt = lower_r;
                default: rdata_nxt = FFL_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Length outputs decoded for the framer
    assign reg_rdata = rdata_r;
    assign complete_byte_count = {upper_r, lower_r[7:4]};
    assign partial_bit_count = lower_r[3:1];
    assign partial_flag = lower_r[FFL_PARTIAL_FLAG_BIT];
    // Count field is ignored unless the flag is set
    assign last_byte_bits = partial_flag ? {1'b0, partial_bit_count} : FFL_FULL_BYTE_BITS;
    assign fill_level_bits = level_r;
    assign fifo_overflow = ovf_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    // Push into a full FIFO raises the error flag
    a_ovf_on_full: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_push && !fifo_pop && level_r == 7'h7f) |=> ovf_r)
        else $error("overflow not flagged on push into full fifo");

    // Lone push counts up by one
    a_level_inc: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_push && !fifo_pop && level_r != 7'h7f)
        |=> level_r == $past(level_r) + 7'h01)
        else $error("fill level did not count up");

    // Lone pop counts down by one
    a_level_dec: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_pop && !fifo_push && level_r != 7'h00)
        |=> level_r == $past(level_r) - 7'h01)
        else $error("fill level did not count down");

    // Upper register lands in count bits 11..4
    a_upper_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !tx_eof && reg_wr && reg_addr == FFL_ADDR_TX_UPPER)
        |=> complete_byte_count[11:4] == $past(reg_wdata))
        else $error("upper count bits not written");

    // Lower register splits into count nibble, bit count and flag
    a_lower_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !tx_eof && reg_wr && reg_addr == FFL_ADDR_TX_LOWER)
        |=> complete_byte_count[3:0] == $past(reg_wdata[7:4]) && partial_bit_count == $past(reg_wdata[3:1])
            && partial_flag == $past(reg_wdata[0]))
        else $error("lower length register not written");

    // Enable low zeroes both length registers
    a_en_low_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !chip_en |=> upper_r == 8'h00 && lower_r == 8'h00)
        else $error("length not zero with enable low");

    // Frame end wipes the whole length
    a_eof_clears: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && tx_eof) |=> complete_byte_count == 12'h000 && !partial_flag ##1 (upper_r == 8'h00 || $past(reg_wr)))
        else $error("frame end did not clear length");

    // Without the flag a full byte goes out
    a_partial_use: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !partial_flag |-> last_byte_bits == 4'h8)
        else $error("partial count used without flag");

    // Host write to the status offset changes nothing
    a_status_ro: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && reg_wr && reg_addr == FFL_ADDR_FILL_STATUS && !fifo_push && !fifo_pop && !fifo_clear)
        |=> $stable(level_r) && $stable(ovf_r))
        else $error("status register changed by host write");

    // --------------------------------------------------------------
    // Corner checks: same-cycle collisions, clear, empty-pop, enable-low and flag cases, and the read path
    // --------------------------------------------------------------
    // A byte lost in the clear cycle must still raise the flag
    a_ovf_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && fifo_clear && fifo_push && !fifo_pop && level_r == 7'h7f) |=> ovf_r)
        else $error("overflow lost against a clear");

    // Flag is sticky until a clear or enable low
    a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && ovf_r) |=> ovf_r)
        else $error("overflow flag dropped on its own");

    // Clear empties the FIFO count
    a_clear_empties: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && fifo_clear) |=> level_r == 7'h00)
        else $error("fill level not emptied by clear");

    // Pop on an empty FIFO must not wrap the count
    a_pop_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_pop && !fifo_push && level_r == 7'h00) |=> level_r == 7'h00)
        else $error("fill level wrapped on empty pop");

    // Push with pop on a non-empty FIFO leaves the count alone
    a_push_pop_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_push && fifo_pop && level_r != 7'h00) |=> $stable(level_r))
        else $error("fill level moved on push with pop");

    // Push with pop on an empty FIFO still stores the byte
    a_push_pop_empty: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && !fifo_clear && fifo_push && fifo_pop && level_r == 7'h00) |=> level_r == 7'h01)
        else $error("byte lost on push with pop when empty");

    // Status read returns flag and count of the read cycle
    a_read_status: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (reg_rd && reg_addr == FFL_ADDR_FILL_STATUS) |=> reg_rdata == {$past(ovf_r), $past(level_r)})
        else $error("status read returned wrong value");

    // Enable low empties the count and drops the flag
    a_en_low_level: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !chip_en |=> level_r == 7'h00 && !ovf_r)
        else $error("fill state kept with enable low");

    // Frame end beats a host write in the same cycle
    a_eof_beats_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chip_en && tx_eof && reg_wr) |=> upper_r == 8'h00 && lower_r == 8'h00)
        else $error("host write survived frame end");

    // With the flag set the bit count goes out as given
    a_flag_selects_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
        partial_flag |-> last_byte_bits == {1'b0, partial_bit_count})
        else $error("partial bit count not used with flag");
endmodule
`default_nettype wire

// ===== ffl_host.sv
// Host register port model: one strobe per call, write data scrambled when idle
`default_nettype none
module ffl_host import ffl_pkg::*; (
    input wire logic ref_clk,
    output logic [4:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {reg_addr, reg_wr, reg_rd, reg_wdata} = 15'h0000;
    end
    // One-cycle write; data inverted after, so a stale byte never looks valid
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk);
        {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask
    // Read data is registered, so it is sampled a cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [7:0] q);
        @(negedge ref_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        q = reg_rdata;
    endtask
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the FIFO status and transmit length registers
`default_nettype none
module tb_top
    import ffl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk, sys_rst, chip_en, fifo_push, fifo_pop, fifo_clear, tx_eof, reg_wr, reg_rd, partial_flag;
    logic fifo_overflow;
    logic [4:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, q;
    logic [11:0] complete_byte_count;
    logic [2:0] partial_bit_count;
    logic [3:0] last_byte_bits;
    logic [6:0] fill_level_bits;
    int n_mismatch, tests_run, cyc;
    // Rows: upper, lower, count, {bit count, flag}, final byte width
    logic [35:0] rows [5] = '{36'h12_34_123_4_8, 36'hff_ff_fff_f_7, 36'h00_01_000_1_0, 36'ha5_5a_a55_a_8,
        36'h80_0b_800_b_5};
    ffl_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_en(chip_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fifo_push(fifo_push), .fifo_pop(fifo_pop),
        .fifo_clear(fifo_clear), .tx_eof(tx_eof), .complete_byte_count(complete_byte_count),
        .partial_bit_count(partial_bit_count), .partial_flag(partial_flag), .last_byte_bits(last_byte_bits),
        .fill_level_bits(fill_level_bits), .fifo_overflow(fifo_overflow));
    ffl_host host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the few hundred cycles needed
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Holds {push, pop, clear, eof} for n cycles
    task automatic strobe(input logic [3:0] s, input int n);
        @(negedge ref_clk);
        {fifo_push, fifo_pop, fifo_clear, tx_eof} = s;
        repeat (n) @(negedge ref_clk);
        {fifo_push, fifo_pop, fifo_clear, tx_eof} = 4'h0;
    endtask
    initial begin
        {chip_en, sys_rst, fifo_push, fifo_pop, fifo_clear, tx_eof} = 6'b110000;
        repeat (4) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk(complete_byte_count, 12'h000);
        host.rd(FFL_ADDR_TX_LOWER, q);
        chk({4'h0, q}, {4'h0, FFL_TX_RESET});
        foreach (rows[i]) begin
            host.wr(FFL_ADDR_TX_UPPER, rows[i][35:28]);
            host.wr(FFL_ADDR_TX_LOWER, rows[i][27:20]);
            chk(complete_byte_count, rows[i][19:8]);
            chk({8'h00, partial_bit_count, partial_flag}, {8'h00, rows[i][7:4]});
            chk({8'h00, last_byte_bits}, {8'h00, rows[i][3:0]});
            host.rd(FFL_ADDR_TX_LOWER, q);
            chk({4'h0, q}, {4'h0, rows[i][27:20]});
        end
        // Frame end wipes a count whose top bit is set
        strobe(4'h1, 1);
        chk(complete_byte_count, 12'h000);
        host.rd(FFL_ADDR_TX_LOWER, q);
        chk({4'h0, q}, 12'h000);
        host.wr(FFL_ADDR_TX_UPPER, 8'hc3);
        strobe(4'h0, 0);
        chip_en = 1'b0;
        strobe(4'h0, 0);
        chip_en = 1'b1;
        chk(complete_byte_count, 12'h000);
        // Frame end and a length write in one cycle: the frame end wins
        host.wr(FFL_ADDR_TX_UPPER, 8'hc3);
        fork
            host.wr(FFL_ADDR_TX_LOWER, 8'h5b);
            strobe(4'h1, 1);
        join
        chk(complete_byte_count, 12'h000);
        chk({8'h00, partial_bit_count, partial_flag}, 12'h000);
        // Fill to the brim, then one byte too many
        strobe(4'h8, 127);
        host.rd(FFL_ADDR_FILL_STATUS, q);
        chk({4'h0, q}, {4'h0, FFL_FIFO_DEPTH});
        strobe(4'h8, 1);
        strobe(4'h4, 1);
        host.wr(FFL_ADDR_FILL_STATUS, 8'h00);
        host.rd(FFL_ADDR_FILL_STATUS, q);
        chk({4'h0, q}, 12'h0fe);
        host.rd(5'h05, q);
        chk({4'h0, q}, {4'h0, FFL_UNMAPPED_READ});
        strobe(4'h2, 1);
        chk({4'h0, fifo_overflow, fill_level_bits}, 12'h000);
        // Byte lost in the very cycle of a clear is still flagged
        strobe(4'h8, 127);
        strobe(4'ha, 1);
        chk({4'h0, fifo_overflow, fill_level_bits}, 12'h080);
        strobe(4'h2, 1);
        // Push with pop on empty counts; pop on empty is ignored; push with pop holds
        strobe(4'hc, 1);
        chk({5'h00, fill_level_bits}, 12'h001);
        strobe(4'h4, 2);
        chk({5'h00, fill_level_bits}, 12'h000);
        strobe(4'h8, 2);
        strobe(4'hc, 1);
        chk({5'h00, fill_level_bits}, 12'h002);
        host.rd(FFL_ADDR_FILL_STATUS, q);
        chk({4'h0, q}, 12'h002);
        // Enable low empties the count but leaves the read data alone
        strobe(4'h0, 0);
        chip_en = 1'b0;
        strobe(4'h0, 0);
        chip_en = 1'b1;
        chk({4'h0, fifo_overflow, fill_level_bits}, 12'h000);
        chk({4'h0, reg_rdata}, 12'h002);
        // Second reset in mid-run, then a write right after it
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk({4'h0, reg_rdata}, 12'h000);
        host.wr(FFL_ADDR_TX_UPPER, 8'h3c);
        chk(complete_byte_count, 12'h3c0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
